// File: hub_cfg_pkg.sv
// constants for the hub configuration and eeprom auto-load block
package hub_cfg_pkg;
  localparam logic [3:0] reg_boost_addr = 4'h0;
  localparam logic [3:0] reg_ctrl_addr = 4'h4;
  localparam logic [3:0] reg_stat_addr = 4'h8;
  localparam logic [3:0] reg_mac_lo_addr = 4'hc;
  localparam logic [7:0] boost_reset = 8'h00;
  localparam logic [7:0] boost_write_mask = 8'hfc;
  localparam int ctrl_regrst_bit = 1;
  localparam int ctrl_attach_bit = 0;
  localparam int stat_done_bit = 0;
  localparam int stat_valid_bit = 1;
  localparam int stat_busy_bit = 2;
  localparam logic [7:0] signature_value = 8'ha5;
  localparam logic [7:0] sig_addr = 8'h00;
  localparam logic [7:0] mac_first_addr = 8'h01;
  localparam logic [7:0] mac_last_addr = 8'h06;
  localparam logic [7:0] fs_poll_addr = 8'h07;
  localparam logic [7:0] hs_poll_addr = 8'h08;
  localparam logic [7:0] cfg_flags_addr = 8'h09;
  localparam logic [7:0] max_power_addr = 8'h0a;
  localparam logic [7:0] vid_lo_addr = 8'h20;
  localparam logic [7:0] vid_hi_addr = 8'h21;
  localparam logic [7:0] pid_lo_addr = 8'h22;
  localparam logic [7:0] pid_hi_addr = 8'h23;
  localparam logic [7:0] config_byte_one_addr = 8'h26;
  localparam logic [7:0] wp_last_addr = 8'hfe;
  localparam logic [47:0] mac_default = 48'hffff_ffff_ffff;
  localparam logic [7:0] fs_poll_default = 8'h01;
  localparam logic [7:0] hs_poll_default = 8'h04;
  localparam logic [7:0] cfg_flags_default = 8'h05;
  localparam logic [7:0] max_power_default = 8'h01;
  localparam logic [7:0] config_byte_one_default = 8'h00;
  localparam logic [31:0] bus_zero = 32'h0000_0000;
  typedef enum logic [1:0] {load_none, load_all, load_mac, load_eth} load_kind_type;
  typedef enum logic [2:0] {st_idle, st_sig_req, st_sig_wait, st_req, st_wait} load_state_type;
endpackage

// File: hub_config_eeprom_autoload.sv
// hub configuration registers and eeprom auto-load engine
//
// Behaviour
// - boost code 00 normal, 01/10/11 +4/8/12%
// - boost bits 7:6 port4, 5:4 port3, 3:2 port2
// - register reset bit restores configuration defaults
// - register reset bit clears itself during reset
// - attach bit one signals upstream attach once load is done
// - attach set blocks writes to 00h-FEh
// - attach writes once, cleared by hard reset
// - bad signature uses mac and poll defaults
// - bad signature flags 05h, power 01h
// - bad signature reports fixed vendor/product ids
// - usb, power, pin, software resets start load
// - read byte 0, continue only on a5
// - hard reset loads hub and ethernet content
// - usb reset loads only ethernet address
// - software reset reloads ethernet content only
// - ethernet address from bytes 01h-06h
// - hub config byte one from byte 26h
`timescale 1ns/1ps
`default_nettype none
module hub_config_eeprom_autoload
  import hub_cfg_pkg::*;
#(
  parameter logic [15:0] vendor_id_default = 16'h1234, // arbitrary value
  parameter logic [15:0] product_id_default = 16'h5678 // arbitrary value
)
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic pin_reset_low,
  input wire logic usb_reset,
  input wire logic software_reset,
  input wire logic reload_cmd,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic cfg_wr_en,
  input wire logic [7:0] cfg_wr_addr,
  input wire logic [7:0] cfg_wr_data,
  output logic cfg_wr_accept,
  output logic ee_rd_req,
  output logic [7:0] ee_rd_addr,
  input wire logic ee_rd_valid,
  input wire logic [7:0] ee_rd_data,
  output logic [1:0] port4_drive_boost,
  output logic [1:0] port3_drive_boost,
  output logic [1:0] port2_drive_boost,
  output logic usb_attach,
  output logic load_done,
  output logic [47:0] mac_addr,
  output logic [7:0] fs_poll_interval,
  output logic [7:0] hs_poll_interval,
  output logic [7:0] eth_config_flags,
  output logic [7:0] eth_max_power,
  output logic [15:0] eth_vendor_id,
  output logic [15:0] eth_product_id,
  output logic [7:0] config_byte_one
);

  ////////////////////////////////////////////////////////////////////////////
  // reset sources
  logic [7:0] boost_q;
  logic attach_q;
  logic attach_written_q;
  logic regrst_q;
  logic hard_rst;
  logic cfg_rst;
  // pin reset and power-on reset clear everything; register reset only configuration
  assign hard_rst = rst | ~pin_reset_low;
  assign cfg_rst = hard_rst | regrst_q;

  ////////////////////////////////////////////////////////////////////////////
  // wishbone slave
  logic bus_req;
  logic wr_boost;
  logic wr_ctrl;
  logic lane0_wr;
  logic [31:0] rd_mux;
  logic ack_q;
  logic [31:0] rdata_q;
  logic valid_q;
  logic busy;
  logic done_q;
  logic hit_boost;
  logic hit_ctrl;
  logic hit_stat;
  logic hit_mac;

  // register select from the bus address
  function automatic logic reg_hit(input logic [3:0] adr, input logic [3:0] offset);
    reg_hit = adr == offset;
  endfunction

  assign hit_boost = reg_hit(wb_adr_i, reg_boost_addr);
  assign hit_ctrl = reg_hit(wb_adr_i, reg_ctrl_addr);
  assign hit_stat = reg_hit(wb_adr_i, reg_stat_addr);
  assign hit_mac = reg_hit(wb_adr_i, reg_mac_lo_addr);
  assign bus_req = wb_cyc_i & wb_stb_i & ~ack_q;
  assign lane0_wr = bus_req & wb_we_i & wb_sel_i[0];
  assign wr_boost = lane0_wr & hit_boost;
  assign wr_ctrl = lane0_wr & hit_ctrl;
  assign rd_mux = hit_boost ? {24'h000000, boost_q} :
                  hit_ctrl ? {30'h0, regrst_q, attach_q} :
                  hit_stat ? {29'h0, busy, valid_q, done_q} :
                  hit_mac ? mac_addr[31:0] : bus_zero;

  // ack is registered: a strobe still high in the ack cycle is not taken twice
  always_ff @(posedge core_clk or posedge hard_rst)
  begin
    if (hard_rst)
    begin
      ack_q <= 1'b0;
      rdata_q <= bus_zero;
    end
    else
    begin
      ack_q <= bus_req;
      rdata_q <= bus_req ? rd_mux : bus_zero;
    end
  end
  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // boost and control registers
  always_ff @(posedge core_clk or posedge cfg_rst)
  begin
    if (cfg_rst)
      boost_q <= boost_reset;
    else if (wr_boost)
      boost_q <= wb_dat_i[7:0] & boost_write_mask;
  end
  // codes pass straight to the phy: 00 normal, 01/10/11 stepped boost
  assign port4_drive_boost = boost_q[7:6];
  assign port3_drive_boost = boost_q[5:4];
  assign port2_drive_boost = boost_q[3:2];

  // self-clearing pulse: its own ~regrst_q term clears it next edge; the forced reset it drives does not
  always_ff @(posedge core_clk or posedge hard_rst)
  begin
    if (hard_rst)
      regrst_q <= 1'b0;
    else
      regrst_q <= wr_ctrl & wb_dat_i[ctrl_regrst_bit] & ~regrst_q;
  end

  // attach survives register reset; only one write is honoured
  always_ff @(posedge core_clk or posedge hard_rst)
  begin
    if (hard_rst)
    begin
      attach_q <= 1'b0;
      attach_written_q <= 1'b0;
    end
    else if (wr_ctrl & ~attach_written_q & ~wb_dat_i[ctrl_regrst_bit])
    begin
      attach_q <= wb_dat_i[ctrl_attach_bit];
      attach_written_q <= 1'b1;
    end
  end
  assign usb_attach = attach_q & done_q;

  // internal configuration memory write gate
  assign cfg_wr_accept = cfg_wr_en & ~(attach_q & (cfg_wr_addr <= wp_last_addr));

  ////////////////////////////////////////////////////////////////////////////
  // auto-load engine
  load_state_type state_q;
  load_kind_type kind_q;
  load_kind_type pend_q;
  logic [7:0] addr_q;
  logic [7:0] last_addr;
  logic [7:0] next_addr;
  logic start;
  logic sig_ok;
  logic take;

  // hard reset queues a full load; others queue subsets, latest wins
  always_ff @(posedge core_clk or posedge hard_rst)
  begin
    if (hard_rst)
      pend_q <= load_all;
    else if (usb_reset)
      pend_q <= load_mac;
    else if (software_reset | reload_cmd)
      pend_q <= load_eth;
    else if (start)
      pend_q <= load_none;
  end

  assign start = (state_q == st_idle) & (pend_q != load_none);
  assign sig_ok = ee_rd_data == signature_value;
  assign take = (state_q == st_wait) & ee_rd_valid;
  assign last_addr = (kind_q == load_all) ? config_byte_one_addr :
                     (kind_q == load_eth) ? pid_hi_addr : mac_last_addr;
  // ethernet subset skips the gap between max power and the id bytes
  assign next_addr = (addr_q == max_power_addr && kind_q != load_mac) ? vid_lo_addr :
                     (addr_q == pid_hi_addr) ? config_byte_one_addr : addr_q + 8'h01;
  assign busy = state_q != st_idle;

  // one byte per wait state; addr_q already holds the next address when the request rises
  always_ff @(posedge core_clk or posedge hard_rst)
  begin
    if (hard_rst)
    begin
      state_q <= st_idle;
      kind_q <= load_none;
      addr_q <= sig_addr;
      done_q <= 1'b0;
      valid_q <= 1'b0;
    end
    else
    begin
      case (state_q)
        st_idle:
          if (start)
          begin
            kind_q <= pend_q;
            done_q <= 1'b0;
            state_q <= st_sig_req;
          end
        st_sig_req:
        begin
          addr_q <= sig_addr;
          state_q <= st_sig_wait;
        end
        st_sig_wait:
          if (ee_rd_valid)
          begin
            valid_q <= sig_ok;
            addr_q <= mac_first_addr;
            if (sig_ok)
              state_q <= st_req;
            else
            begin
              done_q <= 1'b1;
              state_q <= st_idle;
            end
          end
        st_req:
          state_q <= st_wait;
        st_wait:
          if (ee_rd_valid)
          begin
            if (addr_q == last_addr)
            begin
              done_q <= 1'b1;
              state_q <= st_idle;
            end
            else
            begin
              addr_q <= next_addr;
              state_q <= st_req;
            end
          end
        default:
          state_q <= st_idle;
      endcase
    end
  end
  // request stands only in the wait states; the request states are the one-cycle
  // gap in which the next address settles before the reader may sample it
  assign ee_rd_req = (state_q == st_sig_wait) | (state_q == st_wait);
  assign ee_rd_addr = addr_q;
  assign load_done = done_q;

  ////////////////////////////////////////////////////////////////////////////
  // loaded configuration, defaults when signature missing
  logic sig_fail;
  assign sig_fail = (state_q == st_sig_wait) & ee_rd_valid & ~sig_ok;

  // one always block per mac octet, each with its own byte select
  genvar gi;
  generate
    for (gi = 0; gi < 6; gi++)
    begin : g_mac
      always_ff @(posedge core_clk or posedge cfg_rst)
      begin
        if (cfg_rst)
          mac_addr[gi*8 +: 8] <= mac_default[gi*8 +: 8];
        else if (sig_fail & (kind_q != load_none))
          mac_addr[gi*8 +: 8] <= mac_default[gi*8 +: 8];
        else if (take & (addr_q == mac_first_addr + 8'(gi)))
          mac_addr[gi*8 +: 8] <= ee_rd_data;
      end
    end
  endgenerate

  always_ff @(posedge core_clk or posedge cfg_rst)
  begin
    if (cfg_rst)
    begin
      fs_poll_interval <= fs_poll_default;
      hs_poll_interval <= hs_poll_default;
      eth_config_flags <= cfg_flags_default;
      eth_max_power <= max_power_default;
      eth_vendor_id <= vendor_id_default;
      eth_product_id <= product_id_default;
      config_byte_one <= config_byte_one_default;
    end
    // the hub byte keeps its value when the signature is missing
    else if (sig_fail & (kind_q != load_mac))
    begin
      fs_poll_interval <= fs_poll_default;
      hs_poll_interval <= hs_poll_default;
      eth_config_flags <= cfg_flags_default;
      eth_max_power <= max_power_default;
      eth_vendor_id <= vendor_id_default;
      eth_product_id <= product_id_default;
    end
    else if (take)
    begin
      if (addr_q == fs_poll_addr)
        fs_poll_interval <= ee_rd_data;
      if (addr_q == hs_poll_addr)
        hs_poll_interval <= ee_rd_data;
      if (addr_q == cfg_flags_addr)
        eth_config_flags <= ee_rd_data;
      if (addr_q == max_power_addr)
        eth_max_power <= ee_rd_data;
      if (addr_q == vid_lo_addr)
        eth_vendor_id[7:0] <= ee_rd_data;
      if (addr_q == vid_hi_addr)
        eth_vendor_id[15:8] <= ee_rd_data;
      if (addr_q == pid_lo_addr)
        eth_product_id[7:0] <= ee_rd_data;
      if (addr_q == pid_hi_addr)
        eth_product_id[15:8] <= ee_rd_data;
      if (addr_q == config_byte_one_addr)
        config_byte_one <= ee_rd_data;
    end
  end

endmodule
`default_nettype wire

// File: hub_cfg_monitor.sv
// port assertions for the hub configuration block
`timescale 1ns/1ps
`default_nettype none
module hub_cfg_monitor
  import hub_cfg_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic pin_reset_low,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic cfg_wr_en,
  input wire logic [7:0] cfg_wr_addr,
  input wire logic cfg_wr_accept,
  input wire logic ee_rd_req,
  input wire logic [7:0] ee_rd_addr,
  input wire logic ee_rd_valid,
  input wire logic [7:0] ee_rd_data,
  input wire logic usb_attach,
  input wire logic load_done,
  input wire logic [47:0] mac_addr
);
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (rst || !pin_reset_low);
  property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o; endproperty
  a_ack: assert property (p_ack) else $error("ack timing wrong");
  property p_attach; usb_attach |-> load_done; endproperty
  a_attach: assert property (p_attach) else $error("attach before load end");
  property p_prot; cfg_wr_en && usb_attach && cfg_wr_addr <= wp_last_addr |-> !cfg_wr_accept; endproperty
  a_prot: assert property (p_prot) else $error("protected write taken");
  property p_top; cfg_wr_en && cfg_wr_addr == 8'hff |-> cfg_wr_accept; endproperty
  a_top: assert property (p_top) else $error("top address refused");
  property p_idle; !cfg_wr_en |-> !cfg_wr_accept; endproperty
  a_idle: assert property (p_idle) else $error("accept without write");
  property p_gap; ee_rd_req && ee_rd_valid |=> !ee_rd_req; endproperty
  a_gap: assert property (p_gap) else $error("request not dropped");
  property p_sig; ee_rd_req && !$past(ee_rd_req) && $past(load_done, 2) |-> ee_rd_addr == sig_addr; endproperty
  a_sig: assert property (p_sig) else $error("load not begun at byte 0");
  property p_bad; ee_rd_req && ee_rd_valid && ee_rd_addr == sig_addr && ee_rd_data != signature_value
    |-> ##[1:4] load_done && mac_addr == mac_default; endproperty
  a_bad: assert property (p_bad) else $error("bad signature not abandoned");
  c_bad: cover property (ee_rd_valid && ee_rd_addr == sig_addr && ee_rd_data != signature_value);
  c_attach: cover property (usb_attach);
  c_refuse: cover property (cfg_wr_en && !cfg_wr_accept);
endmodule
bind hub_config_eeprom_autoload hub_cfg_monitor hub_cfg_monitor_inst (.*);
`default_nettype wire

// File: eeprom_model.sv
// behavioural serial eeprom answering byte reads after a set latency
`timescale 1ns/1ps
`default_nettype none
module eeprom_model (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ee_rd_req,
  input wire logic [7:0] ee_rd_addr,
  input wire logic [3:0] lat,
  output logic ee_rd_valid,
  output logic [7:0] ee_rd_data
);
  logic [7:0] mem [256];
  logic [3:0] cnt_q;
  always_ff @(posedge core_clk or posedge rst)
    if (rst)
    begin
      cnt_q <= 4'h0;
      ee_rd_valid <= 1'b0;
      ee_rd_data <= 8'h00;
    end
    else
    begin
      ee_rd_valid <= 1'b0;
      // released data line keeps changing
      ee_rd_data <= ~ee_rd_data;
      cnt_q <= 4'h0;
      if (ee_rd_req && !ee_rd_valid && cnt_q != lat)
        cnt_q <= cnt_q + 4'h1;
      else if (ee_rd_req && !ee_rd_valid)
      begin
        ee_rd_valid <= 1'b1;
        ee_rd_data <= mem[ee_rd_addr];
      end
    end
endmodule
`default_nettype wire

// File: tb.sv
// self-checking bench for the hub configuration block
`timescale 1ns/1ps
`default_nettype none
module tb
  import hub_cfg_pkg::*;
;
  logic core_clk = 1'b0, rst = 1'b1, pin_reset_low = 1'b1, usb_reset = 1'b0, software_reset = 1'b0;
  logic reload_cmd = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, cfg_wr_en = 1'b0;
  logic wb_ack_o, cfg_wr_accept, ee_rd_req, ee_rd_valid, usb_attach, load_done;
  logic [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'h1, lat = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
  logic [7:0] cfg_wr_addr = 8'h00, cfg_wr_data = 8'h00, ee_rd_addr, ee_rd_data, c1, d;
  logic [7:0] fs_poll_interval, hs_poll_interval, eth_config_flags, eth_max_power, config_byte_one;
  logic [1:0] port4_drive_boost, port3_drive_boost, port2_drive_boost;
  logic [47:0] mac_addr;
  logic [15:0] eth_vendor_id, eth_product_id;
  int err_count = 0, cmp_count = 0, cyc = 0, seed = 96;
  always #2 core_clk = ~core_clk;
  hub_config_eeprom_autoload #(.vendor_id_default(16'h1111), .product_id_default(16'h2222))
    hub_config_eeprom_autoload_inst (.*);
  eeprom_model eeprom_model_inst (.*);
  function automatic logic [7:0] m(input int a);
    return eeprom_model_inst.mem[a];
  endfunction
  function automatic logic [47:0] mac_exp();
    return {m(6), m(5), m(4), m(3), m(2), m(1)};
  endfunction
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] dat);
    @(posedge core_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= dat;
    do
      @(posedge core_clk);
    while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic load(input logic sig);
    for (int i = 1; i < 256; i++)
      eeprom_model_inst.mem[i] = 8'($random(seed));
    eeprom_model_inst.mem[0] = sig ? signature_value : 8'h5a;
    lat <= 4'($random(seed));
  endtask
  task automatic settle;
    do
      @(posedge core_clk);
    while (ee_rd_req !== 1'b1);
    do
      @(posedge core_clk);
    while (load_done !== 1'b1);
  endtask
  task automatic kick(input int k);
    @(posedge core_clk);
    usb_reset <= (k == 0);
    software_reset <= (k == 1);
    reload_cmd <= (k == 2);
    @(posedge core_clk);
    {usb_reset, software_reset, reload_cmd} <= 3'b000;
  endtask
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      err_count++;
      complete_run;
    end
  end
  initial
  begin
    load(1'b0);
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    settle;
    chk(mac_addr, mac_default);
    chk({fs_poll_interval, hs_poll_interval}, {fs_poll_default, hs_poll_default});
    chk({eth_config_flags, eth_max_power}, {cfg_flags_default, max_power_default});
    chk({eth_vendor_id, eth_product_id}, 32'h1111_2222);
    chk(config_byte_one, config_byte_one_default);
    load(1'b1);
    @(posedge core_clk);
    pin_reset_low <= 1'b0;
    @(posedge core_clk);
    pin_reset_low <= 1'b1;
    settle;
    chk(mac_addr, mac_exp());
    chk({eth_vendor_id, eth_product_id}, {m(8'h21), m(8'h20), m(8'h23), m(8'h22)});
    chk(config_byte_one, m(config_byte_one_addr));
    for (int k = 0; k < 3; k++)
    begin
      load(1'b1);
      q = {fs_poll_interval, hs_poll_interval, eth_config_flags, eth_max_power};
      c1 = config_byte_one;
      kick(k);
      settle;
      chk(mac_addr, mac_exp());
      chk({fs_poll_interval, hs_poll_interval, eth_config_flags, eth_max_power},
        k ? {m(7), m(8), m(9), m(10)} : q);
      chk(config_byte_one, c1);
    end
    for (int c = 0; c < 4; c++)
    begin
      d = 8'($random(seed));
      d[7:2] = {2'(c), 2'(c + 1), 2'(c + 2)};
      wb(1'b1, reg_boost_addr, {24'h0, d});
      wb(1'b0, reg_boost_addr, 32'h0);
      chk(q, {24'h0, d & boost_write_mask});
      chk({port4_drive_boost, port3_drive_boost, port2_drive_boost}, d[7:2]);
    end
    wb(1'b1, 4'h6, 32'hff);
    wb(1'b0, 4'h6, 32'h0);
    chk(q, 32'h0);
    wb(1'b0, reg_stat_addr, 32'h0);
    chk(q, 32'h3);
    wb(1'b1, reg_ctrl_addr, 32'h2);
    wb(1'b0, reg_boost_addr, 32'h0);
    chk(q, 32'h0);
    chk(mac_addr, mac_default);
    wb(1'b0, reg_ctrl_addr, 32'h0);
    chk(q[1], 1'b0);
    cfg_wr_en <= 1'b1;
    cfg_wr_addr <= 8'h10;
    @(posedge core_clk);
    chk(cfg_wr_accept, 1'b1);
    chk(usb_attach, 1'b0);
    wb(1'b1, reg_ctrl_addr, 32'h1);
    @(posedge core_clk);
    chk(usb_attach, 1'b1);
    chk(cfg_wr_accept, 1'b0);
    kick(1);
    do
      @(posedge core_clk);
    while (ee_rd_req !== 1'b1);
    chk(usb_attach, 1'b0);
    do
      @(posedge core_clk);
    while (load_done !== 1'b1);
    chk(usb_attach, 1'b1);
    cfg_wr_addr <= 8'hff;
    wb(1'b1, reg_ctrl_addr, 32'h0);
    wb(1'b1, reg_ctrl_addr, 32'h2);
    @(posedge core_clk);
    chk({usb_attach, cfg_wr_accept}, 2'b11);
    pin_reset_low <= 1'b0;
    @(posedge core_clk);
    chk(usb_attach, 1'b0);
    pin_reset_low <= 1'b1;
    complete_run;
  end
endmodule
`default_nettype wire
